// [logic/divide_by_n_counter.sv]
`timescale 1ns/1ps

// Behaviour
// - Divide the clock by N, 3 to 15999, one-clock pulse per N clocks.
// - Mode selects choose modulus 2/4/5/8/10; second and third low is master preset.
// - First section preset taken from preset bit 0 upward, width by modulus.
// - Last section weighs thousands, uses leftover low preset bits, wrap by modulus.
// - Three cascaded decades load from preset bits 4 to 15, weights 1/10/100.
// - Decades accept presets up to fifteen yet keep decimal weighting.
// - Each full first-section cycle decrements decades and last section by one.
// - Ratio is modulus times weighted decade and last presets plus first preset.
// - With BCD presets maximum ratio is 9999 or 15999 depending on modulus.
// - Out-of-range decade presets extend the maximum ratio per modulus.
// - While master preset is selected all stages load and hold the presets.
// - Leaving master preset starts counting down from the loaded state.
// - First edge after master preset only arms; counting starts on the second.
// - Master preset entered two or fewer cycles before a pulse keeps that pulse.
// - Without master preset, presets reload as the output pulse occurs.
// - Latch enable high holds the output high from the next pulse until low.
// - Latch enable low makes every pulse exactly one clock wide.
module divide_by_n_counter
  import divider_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic modeA,
  input wire logic modeB,
  input wire logic modeC,
  input wire logic outputLatchEnable,
  input wire logic [PRESET_W-1:0] presetBits,
  output logic divOut
);

  logic [SYNC_W-1:0] syncBus;
  logic [2:0] modeSync;
  logic leSync;
  logic [PRESET_W-1:0] presetSync;
  logic [11:0] decadePreset;
  logic mpSel;
  logic [3:0] modulus;
  logic [3:0] firstPreset;
  logic [3:0] lastPreset;
  logic [3:0] lastWrap;
  count_state_t stateReg;
  count_state_t stateNext;
  logic running;
  logic terminal;
  logic restZero;
  logic valueIs2;
  logic stLoadEn;
  logic pendReg;
  logic pendNext;
  logic pulseNow;
  logic divOutReg;
  logic divOutNext;
  logic [3:0] stLoad [STAGES];
  logic [3:0] stWrap [STAGES];
  logic [3:0] stVal [STAGES];
  logic stDec [STAGES];
  logic stZero [STAGES];

  function automatic logic [3:0] decodeModulus(input logic [2:0] code);
    logic [3:0] m;
    m = MOD_DIV10;
    unique case (code)
      MODE_DIV2: m = MOD_DIV2;
      MODE_DIV4: m = MOD_DIV4;
      MODE_DIV5: m = MOD_DIV5;
      MODE_DIV8: m = MOD_DIV8;
      MODE_DIV10: m = MOD_DIV10;
      default: m = MOD_DIV10;
    endcase
    return m;
  endfunction : decodeModulus

  function automatic logic [3:0] lastWrapFor(input logic [3:0] m);
    logic [3:0] w;
    w = LAST_WRAP_DIV10;
    unique case (m)
      MOD_DIV2: w = LAST_WRAP_DIV2;
      MOD_DIV4: w = LAST_WRAP_DIV4;
      MOD_DIV5: w = LAST_WRAP_DIV5;
      MOD_DIV8: w = LAST_WRAP_DIV8;
      default: w = LAST_WRAP_DIV10;
    endcase
    return w;
  endfunction : lastWrapFor

  function automatic logic [RATIO_W-1:0] ratioOf(
    input logic [3:0] m,
    input logic [3:0] f,
    input logic [3:0] d1,
    input logic [3:0] d2,
    input logic [3:0] d3,
    input logic [3:0] l
  );
    logic [RATIO_W-1:0] r;
    r = 16'(l) * WEIGHT_THOUSANDS + 16'(d3) * WEIGHT_HUNDREDS;
    r = r + 16'(d2) * WEIGHT_TENS + 16'(d1);
    r = r * 16'(m) + 16'(f);
    return r;
  endfunction : ratioOf

  pin_sync u_sync (
    .clk(clk),
    .rst(rst),
    .pinIn({modeA, modeB, modeC, outputLatchEnable, presetBits}),
    .pinOut(syncBus)
  );

  assign modeSync = syncBus[19:17];
  assign leSync = syncBus[16];
  assign presetSync = syncBus[15:0];
  assign decadePreset = presetSync[15:4];

  // Second and third selects both low, first ignored
  assign mpSel = !modeSync[1] && !modeSync[0];
  assign modulus = decodeModulus(modeSync);
  assign lastWrap = lastWrapFor(modulus);

  assign firstPreset = (modulus == MOD_DIV2) ? {3'h0, presetSync[0]} :
                       (modulus == MOD_DIV4) ? {2'h0, presetSync[1:0]} :
                       (modulus == MOD_DIV10) ? presetSync[3:0] :
                       {1'h0, presetSync[2:0]};

  assign lastPreset = (modulus == MOD_DIV2) ? {1'h0, presetSync[3:1]} :
                      (modulus == MOD_DIV4) ? {2'h0, presetSync[3:2]} :
                      (modulus == MOD_DIV10) ? RESET_DIGIT :
                      {3'h0, presetSync[3]};

  // Stage 0 first section, 1..3 decades, 4 last section
  assign stLoad[0] = firstPreset;
  assign stLoad[1] = presetSync[7:4];
  assign stLoad[2] = presetSync[11:8];
  assign stLoad[3] = presetSync[15:12];
  assign stLoad[4] = lastPreset;
  assign stWrap[0] = modulus - 4'h1;
  assign stWrap[1] = DECADE_WRAP;
  assign stWrap[2] = DECADE_WRAP;
  assign stWrap[3] = DECADE_WRAP;
  assign stWrap[4] = lastWrap;

  assign running = (stateReg == ST_COUNTING) && !mpSel;
  assign restZero = stZero[1] && stZero[2] && stZero[3] && stZero[4];
  assign terminal = (stateReg == ST_COUNTING) && (stVal[0] == 4'h1) && restZero;

  // Count remaining equals two: two edges before a due pulse
  assign valueIs2 = ((stVal[0] == 4'h2) && restZero) ||
                    ((modulus == MOD_DIV2) && stZero[0] && (stVal[1] == 4'h1) &&
                     stZero[2] && stZero[3] && stZero[4]);

  // Load in master preset, and reload on the output pulse
  assign stLoadEn = !running || terminal;
  assign stDec[0] = running && !terminal;

  genvar gi;
  generate
    for (gi = 1; gi < STAGES; gi++)
    begin : g_borrow
      // A stage steps down when all faster stages wrap
      assign stDec[gi] = stDec[gi-1] && stZero[gi-1];
    end
    for (gi = 0; gi < STAGES; gi++)
    begin : g_stage
      count_stage u_stage (
        .clk(clk),
        .rst(rst),
        .load(stLoadEn),
        .loadValue(stLoad[gi]),
        .wrapValue(stWrap[gi]),
        .decrement(stDec[gi]),
        .value(stVal[gi]),
        .atZero(stZero[gi])
      );
    end
  endgenerate

  // The arming edge loads rather than counts
  assign stateNext = mpSel ? ST_MASTER_PRESET : ST_COUNTING;
  assign pendNext = (stateReg == ST_COUNTING) && mpSel && valueIs2;
  assign pulseNow = terminal || pendReg;
  assign divOutNext = pulseNow || (leSync && divOutReg);
  assign divOut = divOutReg;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      stateReg <= ST_MASTER_PRESET;
      pendReg <= 1'b0;
      divOutReg <= 1'b0;
    end
    else
    begin
      stateReg <= stateNext;
      pendReg <= pendNext;
      divOutReg <= divOutNext;
    end
  end

  // Helper for the period check
  logic [RATIO_W-1:0] expectedN;
  logic [RATIO_W-1:0] sinceLastReg;
  logic [SYNC_W-1:0] cfgPrevReg;
  logic cleanReg;
  logic cfgChange;

  assign expectedN = ratioOf(modulus, firstPreset, stLoad[1], stLoad[2], stLoad[3],
                             lastPreset);
  assign cfgChange = (cfgPrevReg != syncBus);

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sinceLastReg <= 16'h0000;
      cfgPrevReg <= RESET_SYNC;
      cleanReg <= 1'b0;
    end
    else
    begin
      cfgPrevReg <= syncBus;
      if (pulseNow)
        sinceLastReg <= 16'h0001;
      else if (sinceLastReg != 16'hFFFF)
        sinceLastReg <= sinceLastReg + 16'h0001;
      if (pulseNow)
        cleanReg <= running;
      else if (!running || cfgChange || leSync)
        cleanReg <= 1'b0;
    end
  end

  default clocking cb @(posedge clk);
  endclocking

  default disable iff (rst);

  sequence s_enterMp;
    (stateReg == ST_COUNTING) ##0 mpSel;
  endsequence

  sequence s_leaveMp;
    (stateReg == ST_MASTER_PRESET) ##0 !mpSel;
  endsequence

  sequence s_latchHeld;
    (divOutReg && leSync) ##1 leSync;
  endsequence

  property p_singleWidth;
    divOutReg && !leSync |=> !divOutReg;
  endproperty

  property p_latchHold;
    s_latchHeld |-> divOutReg ##1 divOutReg;
  endproperty

  property p_period;
    pulseNow && cleanReg && !cfgChange && (expectedN >= RATIO_MIN)
      |-> sinceLastReg == expectedN;
  endproperty

  pulse_width_a: assert property (p_singleWidth)
    else $error("output pulse longer than one clock with latch enable low");

  latch_hold_a: assert property (p_latchHold)
    else $error("latched output dropped while latch enable high");

  ratio_period_a: assert property (p_period)
    else $error("pulse spacing differs from the programmed ratio");

  mp_decode_a: assert property (mpSel |=> stateReg == ST_MASTER_PRESET)
    else $error("master preset select did not stop counting");

  modulus_decode_a: assert property (
    (modeSync == MODE_DIV5 |-> modulus == MOD_DIV5) and
    (modeSync == MODE_DIV8 |-> modulus == MOD_DIV8) and
    (modeSync == MODE_DIV4 |-> modulus == MOD_DIV4))
    else $error("mode select decoded to the wrong modulus");

  preset_hold_a: assert property (
    mpSel |=> (stVal[0] == $past(firstPreset)) &&
              ({stVal[3], stVal[2], stVal[1]} == $past(decadePreset)))
    else $error("stages not loaded from presets in master preset");

  start_arm_a: assert property (
    s_leaveMp |=> (stateReg == ST_COUNTING) && (stVal[0] == $past(firstPreset)))
    else $error("counting began on the arming edge");

  count_start_a: assert property (
    s_leaveMp ##1 !mpSel |=> stVal[0] != $past(stVal[0]))
    else $error("counter did not start after master preset");

  first_wrap_a: assert property (
    stDec[0] && stZero[0] |=> (stVal[0] == $past(modulus) - 4'h1))
    else $error("first section did not wrap to modulus minus one");

  decade_wrap_a: assert property (
    stDec[1] && stZero[1] |=> stVal[1] == DECADE_WRAP)
    else $error("decade did not wrap to nine");

  last_wrap_a: assert property (
    stDec[4] && stZero[4] |=> stVal[4] == $past(lastWrap))
    else $error("last section wrapped to the wrong value");

  due_pulse_a: assert property (
    (s_enterMp ##0 valueIs2 |-> ##2 divOutReg) and
    (s_enterMp ##0 terminal |-> ##1 divOutReg))
    else $error("pulse due at master preset entry was lost");

  reload_a: assert property (
    terminal && !mpSel |=> (stVal[0] == $past(firstPreset)) && divOutReg)
    else $error("presets not reloaded with the output pulse");

  // Largest ratios reachable with BCD presets
  localparam logic [RATIO_W-1:0] BCD_MAX_ODD = 16'h270F;
  localparam logic [RATIO_W-1:0] BCD_MAX_EVEN = 16'h3E7F;

  logic presetsBcd;

  assign presetsBcd = (stLoad[1] <= DECADE_WRAP) && (stLoad[2] <= DECADE_WRAP) &&
                      (stLoad[3] <= DECADE_WRAP) && (firstPreset <= stWrap[0]);

  bcd_range_a: assert property (
    presetsBcd |-> (((modulus == MOD_DIV5) || (modulus == MOD_DIV10)) ?
                    (expectedN <= BCD_MAX_ODD) : (expectedN <= BCD_MAX_EVEN)))
    else $error("ratio with BCD presets beyond the largest allowed");

  pend_once_a: assert property (pendReg |=> !pendReg)
    else $error("held-over pulse issued more than once");

  mp_quiet_a: assert property (
    (stateReg == ST_MASTER_PRESET) && !pendReg && !leSync |=> !divOutReg)
    else $error("output pulsed while held in master preset");

  arm_quiet_a: assert property (
    s_leaveMp ##0 (!pendReg && !leSync) |=> !divOutReg)
    else $error("output pulsed on the arming edge");

endmodule : divide_by_n_counter

// [common/divider_pkg.sv]
package divider_pkg;

  localparam int DIGIT_W = 4;
  localparam int PRESET_W = 16;
  localparam int RATIO_W = 16;
  localparam int STAGES = 5;
  localparam int SYNC_W = 20;

  // Mode select codes, ordered {first, second, third}
  localparam logic [2:0] MODE_DIV2 = 3'h7;
  localparam logic [2:0] MODE_DIV4 = 3'h3;
  localparam logic [2:0] MODE_DIV5 = 3'h5;
  localparam logic [2:0] MODE_DIV8 = 3'h1;
  localparam logic [2:0] MODE_DIV10 = 3'h6;

  localparam logic [3:0] MOD_DIV2 = 4'h2;
  localparam logic [3:0] MOD_DIV4 = 4'h4;
  localparam logic [3:0] MOD_DIV5 = 4'h5;
  localparam logic [3:0] MOD_DIV8 = 4'h8;
  localparam logic [3:0] MOD_DIV10 = 4'hA;

  // Wrap value of the last section for each first-section modulus
  localparam logic [3:0] LAST_WRAP_DIV2 = 4'h7;
  localparam logic [3:0] LAST_WRAP_DIV4 = 4'h3;
  localparam logic [3:0] LAST_WRAP_DIV5 = 4'h1;
  localparam logic [3:0] LAST_WRAP_DIV8 = 4'h1;
  localparam logic [3:0] LAST_WRAP_DIV10 = 4'h0;
  localparam logic [3:0] DECADE_WRAP = 4'h9;

  localparam logic [15:0] WEIGHT_THOUSANDS = 16'h03E8;
  localparam logic [15:0] WEIGHT_HUNDREDS = 16'h0064;
  localparam logic [15:0] WEIGHT_TENS = 16'h000A;

  localparam logic [3:0] RESET_DIGIT = 4'h0;
  localparam logic [SYNC_W-1:0] RESET_SYNC = 20'h00000;
  localparam logic [15:0] RATIO_MIN = 16'h0003;
  localparam int MASTER_PRESET_MIN_CYCLES = 3;

  typedef enum logic [0:0] {
    ST_MASTER_PRESET = 1'b0,
    ST_COUNTING = 1'b1
  } count_state_t;

endpackage : divider_pkg

// [logic/pin_sync.sv]
`timescale 1ns/1ps

module pin_sync
  import divider_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [SYNC_W-1:0] pinIn,
  output logic [SYNC_W-1:0] pinOut
);

  logic [SYNC_W-1:0] stage1Reg;
  logic [SYNC_W-1:0] stage2Reg;
  logic [SYNC_W-1:0] stage3Reg;
  logic [SYNC_W-1:0] pinOutReg;
  logic [SYNC_W-1:0] agree;

  // A bit is taken only once the second and third stages agree
  assign agree = ~(stage2Reg ^ stage3Reg);
  assign pinOut = pinOutReg;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      stage1Reg <= RESET_SYNC;
      stage2Reg <= RESET_SYNC;
      stage3Reg <= RESET_SYNC;
      pinOutReg <= RESET_SYNC;
    end
    else
    begin
      stage1Reg <= pinIn;
      stage2Reg <= stage1Reg;
      stage3Reg <= stage2Reg;
      pinOutReg <= (agree & stage3Reg) | (~agree & pinOutReg);
    end
  end

endmodule : pin_sync

// [logic/count_stage.sv]
`timescale 1ns/1ps

module count_stage
  import divider_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic load,
  input wire logic [DIGIT_W-1:0] loadValue,
  input wire logic [DIGIT_W-1:0] wrapValue,
  input wire logic decrement,
  output logic [DIGIT_W-1:0] value,
  output logic atZero
);

  logic [DIGIT_W-1:0] valueReg;
  logic [DIGIT_W-1:0] valueNext;

  assign atZero = (valueReg == RESET_DIGIT);
  assign value = valueReg;
  assign valueNext = load ? loadValue :
                     !decrement ? valueReg :
                     atZero ? wrapValue : valueReg - 4'h1;

  always_ff @(posedge clk)
  begin
    if (rst)
      valueReg <= RESET_DIGIT;
    else
      valueReg <= valueNext;
  end

endmodule : count_stage

// [tb/jam_driver.sv]
`timescale 1ns/1ps

module jam_driver
  import divider_pkg::*;
#(
  parameter int MP_HOLD = 6
)
(
  input wire logic clk,
  output logic modeA,
  output logic modeB,
  output logic modeC,
  output logic outputLatchEnable,
  output logic [PRESET_W-1:0] presetBits
);

  // Power-up in master preset
  initial
  begin
    {modeA, modeB, modeC} = 3'h0;
    outputLatchEnable = 1'b0;
    presetBits = 16'h0000;
  end

  task automatic set_mode(input logic [2:0] code);
    {modeA, modeB, modeC} = code;
  endtask : set_mode

  task automatic set_latch(input logic v);
    outputLatchEnable = v;
  endtask : set_latch

  // Jam presets inside master preset, then select the counting mode
  task automatic load(input logic [2:0] code, input logic [PRESET_W-1:0] preset);
    @(negedge clk);
    {modeA, modeB, modeC} = 3'h0;
    presetBits = preset;
    repeat (MP_HOLD) @(negedge clk);
    {modeA, modeB, modeC} = code;
  endtask : load

endmodule : jam_driver

// [tb/programmable_divide_by_n_counter_tb_top.sv]
`timescale 1ns/1ps

`define CHK(nm, exp, got) \
  begin \
    checks++; \
    if ((got) !== (exp)) \
    begin \
      n_errors++; \
      $display("[FAIL] %s expected %0d seen %0d", nm, exp, got); \
    end \
  end

module programmable_divide_by_n_counter_tb_top
  import divider_pkg::*;
;
  localparam int TIMEOUT = 40000;
  // Sync delay plus arming edge before the countdown
  localparam int FIRST_EXTRA = 5;

  typedef struct {
    logic [2:0] code;
    logic [15:0] preset;
    int n;
  } row_t;

  logic clk;
  logic rst;
  logic modeA;
  logic modeB;
  logic modeC;
  logic outputLatchEnable;
  logic [PRESET_W-1:0] presetBits;
  logic divOut;
  int n_errors = 0;
  int checks = 0;
  int cyc = 0;
  int n;
  int highs;
  row_t rows[7];

  divide_by_n_counter divide_by_n_counter_inst (
    .clk(clk),
    .rst(rst),
    .modeA(modeA),
    .modeB(modeB),
    .modeC(modeC),
    .outputLatchEnable(outputLatchEnable),
    .presetBits(presetBits),
    .divOut(divOut)
  );

  jam_driver jam_driver_inst (
    .clk(clk),
    .modeA(modeA),
    .modeB(modeB),
    .modeC(modeC),
    .outputLatchEnable(outputLatchEnable),
    .presetBits(presetBits)
  );

  always #25 clk = ~clk;

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
    begin
      $display("*** PASS ***");
    end
    else
    begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : close_out

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == TIMEOUT)
    begin
      n_errors++;
      close_out();
    end
  end

  // Falling edges until divOut is seen high, -1 if none within lim
  task automatic wait_pulse(input int lim, output int cnt);
    cnt = 0;
    do
    begin
      @(negedge clk);
      cnt++;
    end
    while (divOut !== 1'b1 && cnt < lim);
    if (divOut !== 1'b1)
    begin
      cnt = -1;
    end
  endtask : wait_pulse

  initial
  begin
    clk = 1'b0;
    rst = 1'b1;
    rows[0] = '{MODE_DIV2, 16'h0011, 3};
    rows[1] = '{MODE_DIV4, 16'h0023, 11};
    rows[2] = '{MODE_DIV5, 16'h00F4, 79};
    rows[3] = '{MODE_DIV8, 16'h0037, 31};
    rows[4] = '{MODE_DIV8, 16'h0008, 8000};
    rows[5] = '{MODE_DIV10, 16'h1205, 1205};
    rows[6] = '{MODE_DIV2, 16'h0002, 2000};
    repeat (3) @(negedge clk);
    `CHK("divOut in reset", 1'b0, divOut)
    rst = 1'b0;
    $display("reset test done");

    foreach (rows[i])
    begin
      jam_driver_inst.load(rows[i].code, rows[i].preset);
      wait_pulse(rows[i].n + 20, n);
      `CHK("first pulse delay", rows[i].n + FIRST_EXTRA, n)
      wait_pulse(rows[i].n + 20, n);
      `CHK("period", rows[i].n, n)
      wait_pulse(rows[i].n + 20, n);
      `CHK("repeat period", rows[i].n, n)
      $display("row %0d done", i);
    end

    // Latched output holds past the next due pulse
    jam_driver_inst.set_latch(1'b1);
    jam_driver_inst.load(MODE_DIV8, 16'h0037);
    wait_pulse(60, n);
    `CHK("latched first pulse", 31 + FIRST_EXTRA, n)
    repeat (40) @(negedge clk);
    `CHK("latched level", 1'b1, divOut)
    jam_driver_inst.set_latch(1'b0);
    n = 0;
    while (divOut === 1'b1 && n < 8)
    begin
      @(negedge clk);
      n++;
    end
    `CHK("latch release", 1'b0, divOut)
    `CHK("latch release cycles", 5, n)
    wait_pulse(40, n);
    `CHK("pulse after release", 17, n)
    $display("latch test done");

    // Master preset seen one count before a due pulse
    repeat (26) @(negedge clk);
    jam_driver_inst.set_mode(3'h0);
    wait_pulse(8, n);
    `CHK("late master preset pulse", 5, n)
    highs = 0;
    repeat (60)
    begin
      @(negedge clk);
      highs += int'(divOut === 1'b1);
    end
    `CHK("held in master preset", 0, highs)
    $display("master preset test done");

    // Reset in mid-run silences the output
    jam_driver_inst.load(MODE_DIV8, 16'h0037);
    repeat (20) @(negedge clk);
    rst = 1'b1;
    highs = 0;
    repeat (3)
    begin
      @(negedge clk);
      highs += int'(divOut === 1'b1);
    end
    `CHK("divOut in mid-run reset", 0, highs)
    rst = 1'b0;
    jam_driver_inst.load(MODE_DIV4, 16'h0023);
    wait_pulse(40, n);
    `CHK("pulse after reset", 11 + FIRST_EXTRA, n)
    $display("mid-run reset test done");
    close_out();
  end

endmodule : programmable_divide_by_n_counter_tb_top
